// [eipc_pkg.sv]
// Shared constants and types for the external and pin-change interrupt controller
//
// Contract
// - Vector-select zero puts vectors at program start; one puts them at boot section.
// - Boot-resident vectors plus app-side lock suppress interrupts while running application code.
// - Application vectors plus boot-side lock suppress interrupts while running boot code.
// - Vector-select writes only land within four cycles after the protection signature.
// - Reserved bits of all controller registers always read back as zero.
// - A pin-change pin requests only when its mask bit and group enable are set.
// - A pin whose mask bit is clear never contributes to a pin-change request.
// - Group 3 covers pins 27..24, mask bits 3:0; enabled change raises group-3 request.
// - Group 2 covers pins 23..16, mask at 0x6D; enabled change raises group-2 request.
// - Group 1 covers pins 15..8, mask at 0x6C; enabled change raises group-1 request.
// - Group 0 covers pins 7..0, mask at 0x6B; enabled change raises group-0 request.
// - Group enables in bits 3:0 at 0x68, gated by the global interrupt flag.
// - Sense register at 0x69: pin 1 field in bits 3:2, pin 0 in 1:0.
// - Sense codes: 00 low level, 01 any change, 10 falling, 11 rising edge.
// - Pins are sampled before edge detection; pulses over one clock reliably trigger.
// - External pin requests need their enable bit and the global interrupt flag.
// - Matching pin activity raises a request even when the pin is an output.
// - External flag sets on trigger, clears on service or written one, zero in level mode.
// - Group flag sets on enabled pin change, clears on service or written one.
// - Pin-change and low-level detection need no edge clock; edges need the clock. Here all of them go through clocked sampling.
package eipc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_GROUP_ENABLE = 8'h68;
  localparam logic [7:0] IDX_SENSE = 8'h69;
  localparam logic [7:0] IDX_MASK0 = 8'h6b;
  localparam logic [7:0] IDX_MASK1 = 8'h6c;
  localparam logic [7:0] IDX_MASK2 = 8'h6d;
  localparam logic [7:0] IDX_VECTOR_CTRL = 8'h70;
  localparam logic [7:0] IDX_MASK3 = 8'h71;
  localparam logic [7:0] IDX_EXT_ENABLE = 8'h72;
  localparam logic [7:0] IDX_EXT_FLAGS = 8'h73;
  localparam logic [7:0] IDX_GROUP_FLAGS = 8'h74;
  localparam logic [7:0] IDX_CHANGE_PROT = 8'h75;

  // Bus geometry
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int IDX_LSB = 2;

  // Implemented-bit masks; everything else reads zero
  localparam logic [7:0] MASK_NIBBLE = 8'h0f;
  localparam logic [7:0] MASK_PAIR = 8'h03;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam int VSEL_BIT = 1;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Sense field encodings
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_ANY = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;
  localparam int SENSE1_LSB = 2;
  localparam int SENSE0_LSB = 0;

  // Protected-write window, one instruction per clock
  localparam logic [2:0] PROT_WINDOW_CYCLES = 3'h4;

  // Pin-change geometry
  localparam int NUM_PC_PINS = 28;
  localparam int NUM_GROUPS = 4;
  localparam int NUM_EXT = 2;

  // Per-source request vector toward the core
  typedef struct packed {
    logic [3:0] pcg;
    logic [1:0] ext;
  } eipc_irq_t;

endpackage

// [eipc_sense.sv]
// Sampled edge and level detector for one dedicated external interrupt pin
`timescale 1ns/10ps
`default_nettype none
module eipc_sense
  import eipc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pin_in,
  input wire logic [1:0] mode_in,
  output logic edge_trig_out,
  output logic low_level_out
);

  logic samp_q;
  logic prev_q;
  wire rise_w;
  wire fall_w;

  // Two-stage sample so edges are judged on registered values
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      samp_q <= 1'b1;
      prev_q <= 1'b1;
    end
    else
    begin
      samp_q <= pin_in;
      prev_q <= samp_q;
    end
  end

  // Trigger select per sense code; low level is reported separately
  assign rise_w = samp_q & ~prev_q;
  assign fall_w = ~samp_q & prev_q;
  assign edge_trig_out = (mode_in == SENSE_ANY) ? (rise_w | fall_w) :
                         (mode_in == SENSE_FALL) ? fall_w :
                         (mode_in == SENSE_RISE) ? rise_w : 1'b0;
  // Level path skips the edge history so it tracks the first sample stage
  assign low_level_out = (mode_in == SENSE_LOW) & ~samp_q;

  a_rise_detect: assert property (@(posedge clk_in) disable iff (rst_in)
    (mode_in == SENSE_RISE && $past(pin_in) && !$past(pin_in, 2) &&
    !$past(rst_in) && !$past(rst_in, 2)) |-> edge_trig_out)
    else $error("rising edge not reported");

endmodule
`default_nettype wire

// [eipc_ctrl.sv]
// External and pin-change interrupt controller with Avalon-MM register slave
`timescale 1ns/10ps
`default_nettype none
module eipc_ctrl #(
  parameter logic [7:0] PROT_SIGNATURE = 8'h5a // Arbitrary unlock value
) (
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  input wire logic [eipc_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [eipc_pkg::DATA_W-1:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [eipc_pkg::DATA_W-1:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  input wire logic [eipc_pkg::NUM_EXT-1:0] EXT_PIN_IN,
  input wire logic [eipc_pkg::NUM_PC_PINS-1:0] PIN_CHANGE_IN,
  input wire logic GLOBAL_IRQ_ENABLE_IN,
  input wire logic APP_SIDE_BOOT_LOCK_IN,
  input wire logic BOOT_SIDE_BOOT_LOCK_IN,
  input wire logic EXEC_FROM_BOOT_IN,
  input wire eipc_pkg::eipc_irq_t IRQ_SERVICED_IN,
  output eipc_pkg::eipc_irq_t IRQ_PENDING_OUT,
  output logic VECTOR_BASE_SELECT_OUT
);
  import eipc_pkg::*;

  // Index match on a word-aligned byte address
  function automatic logic idx_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    idx_hit = (addr[ADDR_W-1:IDX_LSB] == idx);
  endfunction

  // Any masked change inside one group of pins
  // Padded to whole groups so the top group never selects past the last pin
  function automatic logic group_any(input logic [NUM_PC_PINS-1:0] chg, input int grp);
    logic [NUM_GROUPS*8-1:0] padded;
    logic [7:0] slice;
    padded = '0;
    padded[NUM_PC_PINS-1:0] = chg;
    slice = padded[grp*8 +: 8];
    if (grp == NUM_GROUPS - 1)
      slice = slice & MASK_NIBBLE;
    group_any = |slice;
  endfunction

  // Register state
  logic wait_q;
  logic [DATA_W-1:0] rdata_q;
  logic vsel_q;
  logic [2:0] win_cnt_q;
  logic [3:0] sense_q;
  logic [3:0] grp_en_q;
  logic [7:0] mask0_q;
  logic [7:0] mask1_q;
  logic [7:0] mask2_q;
  logic [3:0] mask3_q;
  logic [1:0] ext_en_q;
  logic [1:0] eif_q;
  logic [1:0] eif_d;
  logic [3:0] pcif_q;
  logic [3:0] pcif_d;
  logic [NUM_PC_PINS-1:0] pc_samp_q;
  logic [NUM_PC_PINS-1:0] pc_prev_q;
  eipc_irq_t pend_q;
  eipc_irq_t pend_d;

  // Bus decode
  wire req_w = AVS_READ_IN | AVS_WRITE_IN;
  wire take_w = req_w & ~wait_q;
  wire wr_w = take_w & AVS_WRITE_IN & AVS_BYTEENABLE_IN[0];
  wire [7:0] wbyte_w = AVS_WRITEDATA_IN[7:0];
  wire sel_grp_en_w = idx_hit(AVS_ADDRESS_IN, IDX_GROUP_ENABLE);
  wire sel_sense_w = idx_hit(AVS_ADDRESS_IN, IDX_SENSE);
  wire sel_mask0_w = idx_hit(AVS_ADDRESS_IN, IDX_MASK0);
  wire sel_mask1_w = idx_hit(AVS_ADDRESS_IN, IDX_MASK1);
  wire sel_mask2_w = idx_hit(AVS_ADDRESS_IN, IDX_MASK2);
  wire sel_mask3_w = idx_hit(AVS_ADDRESS_IN, IDX_MASK3);
  wire sel_vctrl_w = idx_hit(AVS_ADDRESS_IN, IDX_VECTOR_CTRL);
  wire sel_ext_en_w = idx_hit(AVS_ADDRESS_IN, IDX_EXT_ENABLE);
  wire sel_eif_w = idx_hit(AVS_ADDRESS_IN, IDX_EXT_FLAGS);
  wire sel_pcif_w = idx_hit(AVS_ADDRESS_IN, IDX_GROUP_FLAGS);
  wire sel_prot_w = idx_hit(AVS_ADDRESS_IN, IDX_CHANGE_PROT);

  // Protection window: signature opens it, count runs down each cycle
  wire prot_ok_w = wr_w & sel_prot_w & (wbyte_w == PROT_SIGNATURE);
  wire win_open_w = (win_cnt_q != 3'h0);
  wire vsel_wr_w = wr_w & sel_vctrl_w & win_open_w;

  // Read mux; unimplemented bits and unmapped indices return zero
  wire [7:0] vctrl_rd_w = {6'h00, vsel_q, 1'b0};
  wire [7:0] rd_byte_w =
    sel_grp_en_w ? {4'h0, grp_en_q} :
    sel_sense_w ? {4'h0, sense_q} :
    sel_mask0_w ? mask0_q :
    sel_mask1_w ? mask1_q :
    sel_mask2_w ? mask2_q :
    sel_mask3_w ? {4'h0, mask3_q} :
    sel_vctrl_w ? vctrl_rd_w :
    sel_ext_en_w ? {6'h00, ext_en_q} :
    sel_eif_w ? {6'h00, eif_q} :
    sel_pcif_w ? {4'h0, pcif_q} : 8'h00;

  // External pin detectors, one per dedicated pin
  wire [1:0] ext_trig_w;
  wire [1:0] ext_low_w;
  wire [1:0] ext_level_mode_w;
  assign ext_level_mode_w[0] = (sense_q[SENSE0_LSB +: 2] == SENSE_LOW);
  assign ext_level_mode_w[1] = (sense_q[SENSE1_LSB +: 2] == SENSE_LOW);

  eipc_sense u_sense0 (
    .clk_in(REF_CLK_IN),
    .rst_in(RESET_IN),
    .pin_in(EXT_PIN_IN[0]),
    .mode_in(sense_q[SENSE0_LSB +: 2]),
    .edge_trig_out(ext_trig_w[0]),
    .low_level_out(ext_low_w[0])
  );

  eipc_sense u_sense1 (
    .clk_in(REF_CLK_IN),
    .rst_in(RESET_IN),
    .pin_in(EXT_PIN_IN[1]),
    .mode_in(sense_q[SENSE1_LSB +: 2]),
    .edge_trig_out(ext_trig_w[1]),
    .low_level_out(ext_low_w[1])
  );

  // Pin-change detection: compare sampled pins, then apply per-pin masks
  wire [NUM_PC_PINS-1:0] pc_mask_w = {mask3_q, mask2_q, mask1_q, mask0_q};
  wire [NUM_PC_PINS-1:0] pc_chg_w = (pc_samp_q ^ pc_prev_q) & pc_mask_w;
  wire [3:0] grp_hit_w;
  assign grp_hit_w[0] = group_any(pc_chg_w, 0);
  assign grp_hit_w[1] = group_any(pc_chg_w, 1);
  assign grp_hit_w[2] = group_any(pc_chg_w, 2);
  assign grp_hit_w[3] = group_any(pc_chg_w, 3);

  // Boot-lock suppression depends on where vectors live and where code runs
  wire suppress_w = (vsel_q & APP_SIDE_BOOT_LOCK_IN & ~EXEC_FROM_BOOT_IN) |
                    (~vsel_q & BOOT_SIDE_BOOT_LOCK_IN & EXEC_FROM_BOOT_IN);
  wire core_ok_w = GLOBAL_IRQ_ENABLE_IN & ~suppress_w;

  // Flag next state: set beats clear so a coincident event is kept
  always_comb
  begin
    eif_d = eif_q & ~IRQ_SERVICED_IN.ext;
    if (wr_w && sel_eif_w)
      eif_d = eif_d & ~wbyte_w[1:0];
    eif_d = (eif_d | ext_trig_w) & ~ext_level_mode_w;
    pcif_d = pcif_q & ~IRQ_SERVICED_IN.pcg;
    if (wr_w && sel_pcif_w)
      pcif_d = pcif_d & ~wbyte_w[3:0];
    pcif_d = pcif_d | grp_hit_w;
  end

  // Requests toward the core, gated by enables and the global flag
  always_comb
  begin
    pend_d.pcg = pcif_q & grp_en_q & {4{core_ok_w}};
    pend_d.ext = ((eif_q & ~ext_level_mode_w) | (ext_low_w & ext_level_mode_w))
                 & ext_en_q & {2{core_ok_w}};
  end

  // Avalon handshake: one wait cycle, then answer
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      wait_q <= 1'b1;
      rdata_q <= '0;
    end
    else
    begin
      wait_q <= ~(req_w & wait_q);
      rdata_q <= (AVS_READ_IN & wait_q) ? {24'h000000, rd_byte_w} : '0;
    end
  end

  // Protection counter
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
      win_cnt_q <= 3'h0;
    else if (prot_ok_w)
      win_cnt_q <= PROT_WINDOW_CYCLES;
    else if (win_open_w)
      win_cnt_q <= win_cnt_q - 3'h1;
  end

  // Vector base select, changed only through the protected path
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
      vsel_q <= 1'b0;
    else if (vsel_wr_w)
      vsel_q <= wbyte_w[VSEL_BIT];
  end

  // Plain configuration registers, reserved bits never stored
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      sense_q <= REG_RESET[3:0];
      grp_en_q <= REG_RESET[3:0];
      ext_en_q <= REG_RESET[1:0];
    end
    else if (wr_w)
    begin
      if (sel_sense_w)
        sense_q <= wbyte_w[3:0];
      if (sel_grp_en_w)
        grp_en_q <= wbyte_w[3:0];
      if (sel_ext_en_w)
        ext_en_q <= wbyte_w[1:0];
    end
  end

  // Per-pin mask registers
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      mask0_q <= REG_RESET;
      mask1_q <= REG_RESET;
      mask2_q <= REG_RESET;
      mask3_q <= REG_RESET[3:0];
    end
    else if (wr_w)
    begin
      if (sel_mask0_w)
        mask0_q <= wbyte_w & MASK_FULL;
      if (sel_mask1_w)
        mask1_q <= wbyte_w & MASK_FULL;
      if (sel_mask2_w)
        mask2_q <= wbyte_w & MASK_FULL;
      if (sel_mask3_w)
        mask3_q <= wbyte_w[3:0];
    end
  end

  // Pin sampling and flags; reset samples zero, so a high pin after reset
  // reads as one change
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      pc_samp_q <= '0;
      pc_prev_q <= '0;
      eif_q <= 2'h0;
      pcif_q <= 4'h0;
      pend_q <= '0;
    end
    else
    begin
      pc_samp_q <= PIN_CHANGE_IN;
      pc_prev_q <= pc_samp_q;
      eif_q <= eif_d;
      pcif_q <= pcif_d;
      pend_q <= pend_d;
    end
  end

  assign AVS_WAITREQUEST_OUT = wait_q;
  assign AVS_READDATA_OUT = rdata_q;
  assign IRQ_PENDING_OUT = pend_q;
  assign VECTOR_BASE_SELECT_OUT = vsel_q;

  // Checks
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RESET_IN);

  sequence s_unlock;
    prot_ok_w ##1 (!prot_ok_w) [*4];
  endsequence

  a_window_close: assert property (s_unlock |=> !win_open_w)
    else $error("protection window stays open too long");

  a_window_open: assert property (prot_ok_w |=> win_open_w [*4])
    else $error("protection window shorter than four cycles");

  a_vsel_guard: assert property ($changed(vsel_q) |-> $past(vsel_wr_w))
    else $error("vector select changed without unlock");

  a_reserved_zero: assert property (AVS_READDATA_OUT[DATA_W-1:8] == '0 &&
    (AVS_READDATA_OUT[7:4] == 4'h0 ||
    $past(sel_mask0_w) || $past(sel_mask1_w) || $past(sel_mask2_w)))
    else $error("reserved read bits not zero");

  a_group_gate: assert property ((IRQ_PENDING_OUT.pcg & ~$past(grp_en_q)) == 4'h0)
    else $error("group request without group enable");

  a_group_flag: assert property (grp_hit_w[0] |=> pcif_q[0] ##1
    (pcif_q[0] || $past(IRQ_SERVICED_IN.pcg[0]) || ($past(wr_w) && $past(sel_pcif_w))))
    else $error("group 0 change not flagged");

  a_level_flag: assert property (ext_level_mode_w[0] |=> !eif_q[0])
    else $error("external flag set in level mode");

  a_ext_gate: assert property (IRQ_PENDING_OUT.ext[1] |->
    $past(ext_en_q[1]) && $past(GLOBAL_IRQ_ENABLE_IN))
    else $error("external request without enable");

  a_lock_mute: assert property (suppress_w |=> IRQ_PENDING_OUT == '0)
    else $error("request raised while boot lock suppresses");

  a_bus_answer: assert property ((req_w && wait_q) |=> !AVS_WAITREQUEST_OUT
    ##1 AVS_WAITREQUEST_OUT)
    else $error("bus answer not one cycle after request");

  // Landed vector writes carry the written bit
  a_window_land: assert property (vsel_wr_w |=>
    vsel_q == $past(wbyte_w[VSEL_BIT]))
    else $error("vector select write did not land");

  // Level mode follows the live pin, two register stages late
  sequence s_level_low0;
    ext_level_mode_w[0] && ext_low_w[0] && ext_en_q[0] && core_ok_w;
  endsequence

  a_level_request: assert property (s_level_low0 |=> IRQ_PENDING_OUT.ext[0])
    else $error("low level on pin zero not requested");

  a_level_release: assert property ((ext_level_mode_w[0] && !ext_low_w[0]) |=>
    !IRQ_PENDING_OUT.ext[0])
    else $error("pin zero request outlived its low level");

  // An armed group flag reaches the core on the next edge
  sequence s_group1_armed;
    pcif_q[1] && grp_en_q[1] && core_ok_w;
  endsequence

  a_group_raise: assert property (s_group1_armed |=> IRQ_PENDING_OUT.pcg[1])
    else $error("armed group 1 not requested");

  // A trigger must survive a clear in the same cycle
  a_flag_set_wins: assert property ((ext_trig_w[1] && !ext_level_mode_w[1]) |=>
    eif_q[1])
    else $error("pin one trigger lost");

  // Read data idles at zero outside a read answer
  a_read_quiet: assert property ((!$past(AVS_READ_IN) || !$past(wait_q)) |->
    AVS_READDATA_OUT == '0)
    else $error("read data not zero outside a read");

endmodule
`default_nettype wire

// [eipc_core_model.sv]
// Behavioural processor core that services pending requests
`timescale 1ns/10ps
`default_nettype none
module eipc_core_model
  import eipc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic svc_en_in,
  input wire logic [3:0] delay_in,
  input wire eipc_pkg::eipc_irq_t pend_in,
  output eipc_pkg::eipc_irq_t svc_out
);
  logic [3:0] cnt_q;
  logic [5:0] pend_w;
  logic [5:0] pick_w;

  // Lowest pending source first, one per pulse
  assign pend_w = pend_in;
  assign pick_w = pend_w & (~pend_w + 6'h01);

  // Service after a chosen latency; a short delay may service one source twice
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_q <= 4'h0;
      svc_out <= '0;
    end
    else if (svc_en_in && pend_w != 6'h00 && cnt_q >= delay_in)
    begin
      cnt_q <= 4'h0;
      svc_out <= eipc_irq_t'(pick_w);
    end
    else
    begin
      cnt_q <= (pend_w != 6'h00 && cnt_q != 4'hf) ? cnt_q + 4'h1 : 4'h0;
      svc_out <= '0;
    end
  end
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the external and pin-change interrupt controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import eipc_pkg::*;
  localparam logic [7:0] SIG = 8'h5a; // Arbitrary unlock value
  logic clk, rst, rd, wr, gie, app_lock, boot_lock, exec_boot, svc_en, wait_rq, vsel;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0] be, dly;
  logic [NUM_EXT-1:0] ext;
  logic [NUM_PC_PINS-1:0] pc;
  eipc_irq_t svc, pend;
  logic [7:0] exp_q[$];
  logic [7:0] idx_a [0:10] = '{8'h68, 8'h69, 8'h6b, 8'h6c, 8'h6d, 8'h71, 8'h72, 8'h73,
    8'h74, 8'h75, 8'h7f};
  logic [7:0] msk_a [0:10] = '{8'h0f, 8'h0f, 8'hff, 8'hff, 8'hff, 8'h0f, 8'h03, 8'h00,
    8'h00, 8'h00, 8'h00};
  int failures, checks_done;

  eipc_ctrl #(.PROT_SIGNATURE(SIG)) DUT (.REF_CLK_IN(clk), .RESET_IN(rst),
    .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
    .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_rq),
    .EXT_PIN_IN(ext), .PIN_CHANGE_IN(pc), .GLOBAL_IRQ_ENABLE_IN(gie),
    .APP_SIDE_BOOT_LOCK_IN(app_lock), .BOOT_SIDE_BOOT_LOCK_IN(boot_lock),
    .EXEC_FROM_BOOT_IN(exec_boot), .IRQ_SERVICED_IN(svc), .IRQ_PENDING_OUT(pend),
    .VECTOR_BASE_SELECT_OUT(vsel));

  eipc_core_model core (.clk_in(clk), .rst_in(rst), .svc_en_in(svc_en), .delay_in(dly),
    .pend_in(pend), .svc_out(svc));

  // Free-running 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic wrap_up();
    if (failures == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask

  // One Avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
    input logic [3:0] lanes);
    int n;
    n = 0;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= {idx, 2'h0};
    wdata <= {24'($urandom), d};
    be <= lanes;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wait_rq !== 1'b0 && n < 20);
    if (wait_rq !== 1'b0)
    begin
      failures++;
      wrap_up();
    end
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, idx, 8'h00, 4'hf);
  endtask

  // Bounded wait for the pending vector to reach the expected value
  task automatic pend_chk(input logic [5:0] e);
    int n;
    repeat (4) @(posedge clk);
    for (n = 0; n < 20 && pend !== e; n++)
      @(posedge clk);
    cmp("pending", {26'h0, e}, {26'h0, pend});
  endtask

  // Each completed read is matched against the oldest note
  always @(posedge clk)
  begin
    if (rd === 1'b1 && wait_rq === 1'b0)
    begin
      if (exp_q.size() == 0)
        cmp("read note", 32'h1, 32'h0);
      else
        cmp("read data", {24'h0, exp_q.pop_front()}, rdata);
    end
  end

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge clk);
    failures++;
    wrap_up();
  end

  initial
  begin
    int p, g, e, m;
    logic [7:0] mi;
    void'($urandom(32'h584b0cf8));
    {rd, wr, gie, app_lock, boot_lock, exec_boot, svc_en} = '0;
    {addr, wdata, be, dly, pc} = '0;
    ext = 2'h3;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // Reset values, reserved bits and unmapped space
    for (int i = 0; i < 11; i++)
    begin
      rd_chk(idx_a[i], 8'h00);
      bus(1'b1, idx_a[i], 8'hff, 4'hf);
      rd_chk(idx_a[i], msk_a[i]);
      bus(1'b1, idx_a[i], 8'h00, 4'hf);
    end
    bus(1'b1, 8'h6b, 8'hff, 4'h0);
    rd_chk(8'h6b, 8'h00);
    rd_chk(8'h70, 8'h00);
    // Protected vector select, window edge on both sides
    bus(1'b1, 8'h75, SIG, 4'hf);
    bus(1'b1, 8'h70, 8'h02, 4'hf);
    rd_chk(8'h70, 8'h02);
    cmp("vector base", 32'h1, {31'h0, vsel});
    bus(1'b1, 8'h75, SIG, 4'hf);
    repeat (2) @(posedge clk);
    bus(1'b1, 8'h70, 8'h00, 4'hf);
    rd_chk(8'h70, 8'h02);
    bus(1'b1, 8'h75, SIG, 4'hf);
    @(posedge clk);
    bus(1'b1, 8'h70, 8'h00, 4'hf);
    @(posedge clk);
    cmp("vector base", 32'h0, {31'h0, vsel});
    // Pin-change groups: mask, group enable, global flag, service
    gie <= 1'b1;
    for (g = 0; g < 4; g++)
    begin
      p = (g == 3) ? $urandom_range(3) : $urandom_range(7);
      mi = (g == 3) ? 8'h71 : 8'h6b + 8'(g);
      bus(1'b1, mi, 8'h01 << p, 4'hf);
      pc[8*g + (p ^ 1)] <= !pc[8*g + (p ^ 1)];
      pend_chk(6'h00);
      rd_chk(8'h74, 8'h00);
      pc[8*g + p] <= !pc[8*g + p];
      pend_chk(6'h00);
      rd_chk(8'h74, 8'h01 << g);
      bus(1'b1, 8'h68, 8'h01 << g, 4'hf);
      pend_chk({4'h1 << g, 2'h0});
      gie <= 1'b0;
      pend_chk(6'h00);
      gie <= 1'b1;
      dly <= (g[0]) ? 4'h9 : 4'h2;
      svc_en <= 1'b1;
      pend_chk(6'h00);
      svc_en <= 1'b0;
      rd_chk(8'h74, 8'h00);
      bus(1'b1, mi, 8'h00, 4'hf);
    end
    // Lock suppression with group 0 kept pending
    bus(1'b1, 8'h75, SIG, 4'hf);
    bus(1'b1, 8'h70, 8'h02, 4'hf);
    app_lock <= 1'b1;
    bus(1'b1, 8'h6b, 8'h01, 4'hf);
    bus(1'b1, 8'h68, 8'h01, 4'hf);
    pc[0] <= !pc[0];
    pend_chk(6'h00);
    exec_boot <= 1'b1;
    pend_chk(6'h04);
    bus(1'b1, 8'h75, SIG, 4'hf);
    bus(1'b1, 8'h70, 8'h00, 4'hf);
    boot_lock <= 1'b1;
    pend_chk(6'h00);
    exec_boot <= 1'b0;
    pend_chk(6'h04);
    bus(1'b1, 8'h74, 8'h01, 4'hf);
    pend_chk(6'h00);
    {app_lock, boot_lock} <= 2'h0;
    // External pins in every sense mode
    for (e = 0; e < 2; e++)
    begin
      bus(1'b1, 8'h72, 8'h01 << e, 4'hf);
      for (m = 0; m < 4; m++)
      begin
        bus(1'b1, 8'h69, 8'(m) << (2 * e), 4'hf);
        ext[e] <= 1'b0;
        pend_chk((m != 3) ? 6'h01 << e : 6'h00);
        if (m == 0)
          rd_chk(8'h73, 8'h00);
        ext[e] <= 1'b1;
        pend_chk((m != 0) ? 6'h01 << e : 6'h00);
        bus(1'b1, 8'h73, 8'h01 << e, 4'hf);
        rd_chk(8'h73, 8'h00);
        pend_chk(6'h00);
      end
    end
    wrap_up();
  end
endmodule
`default_nettype wire
